// ===== mcdbo_regs.svh
/*
 * Constants of the compare / decrement / decimal-adjust datapath slice:
 * reset values, adjust figures and cycle counts.
 * Assumes it is included by bare name wherever these macros are needed.
 */
`ifndef MCDBO_REGS_SVH
`define MCDBO_REGS_SVH

// reset values
`define MCDBO_RST_BYTE 8'h00
`define MCDBO_RST_ADDR 6'h00
`define MCDBO_RST_BIT 1'b0

// register addressing
`define MCDBO_ADDR_W 6
`define MCDBO_DATA_W 8

// destination select field values
`define MCDBO_DEST_ACCUM 1'b0
`define MCDBO_DEST_REG 1'b1

// decimal adjust figures
`define MCDBO_ADJ_LO_ADD 8'h06
`define MCDBO_ADJ_HI_ADD 8'h60
`define MCDBO_NIB_MAX 4'h9

// cycle counts of the documented instructions
`define MCDBO_CYC_PLAIN 1
`define MCDBO_CYC_SKIP 2

`endif

// ===== mcdbo_pkg.sv
/*
 * Types of the compare / decrement / decimal-adjust datapath slice:
 * operation codes, state codes, request and result carriers.
 * Assumes mcdbo_regs.svh is on the include path.
 */
`default_nettype none
`include "mcdbo_regs.svh"

package mcdbo_pkg;

    typedef enum logic [1:0] {
        MCDBO_OP_COMPARE_ACC_WITH_REG = 2'h0,
        MCDBO_OP_DECREMENT_REG = 2'h1,
        MCDBO_OP_DECIMAL_ADJUST_ACC = 2'h2,
        MCDBO_OP_DECREMENT_SKIP_IF_ZERO = 2'h3
    } mcdbo_op_t;

    typedef enum logic [1:0] {
        MCDBO_ST_RUN = 2'b01,
        MCDBO_ST_SKIP = 2'b10
    } mcdbo_fsm_t;

    // one decoded instruction with its operands
    typedef struct packed {
        mcdbo_op_t op;
        logic [`MCDBO_ADDR_W-1:0] reg_addr;
        logic dest;
        logic [`MCDBO_DATA_W-1:0] reg_data;
        logic [`MCDBO_DATA_W-1:0] accumulator;
        logic carry;
    } mcdbo_req_t;

    // write-back of one instruction; enables are one-cycle pulses
    typedef struct packed {
        logic accum_we;
        logic [`MCDBO_DATA_W-1:0] accum_data;
        logic reg_we;
        logic [`MCDBO_ADDR_W-1:0] reg_addr;
        logic [`MCDBO_DATA_W-1:0] reg_data;
        logic zero_we;
        logic zero;
        logic carry_we;
        logic carry;
        logic squash;
    } mcdbo_res_t;

    typedef struct packed {
        mcdbo_fsm_t fsm;
        logic busy;
        mcdbo_res_t res;
    } mcdbo_state_t;

endpackage : mcdbo_pkg

`default_nettype wire

// ===== mcdbo_core.sv
/*
 * Execution slice of an 8-bit core for four instructions: compare the
 * accumulator with a register, decrement a register, decimal-adjust the
 * accumulator, decrement and skip if zero. Each request is taken in one
 * cycle and its write-back appears, registered, in the next.
 * Assumes the core presents operands already read (register 0..63 and the
 * accumulator), applies the write-back pulses, and drops the instruction
 * fetched behind a skip while o_squash is high.
 */
//
// Notes on behaviour
// - compare: register minus accumulator, zero and carry updated, one cycle.
// - compare discards its difference; accumulator and register stay untouched.
// - decrement: register minus one to accumulator or register; zero only; one cycle.
// - decimal adjust rewrites the accumulator in packed decimal; carry only; one cycle.
// - decrement-and-skip stores register minus one to accumulator or register.
// - zero result cancels the fetched next instruction; two cycles, else one.
`timescale 1ns/1ps
`default_nettype none
`include "mcdbo_regs.svh"

module mcdbo_core (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire mcdbo_pkg::mcdbo_req_t i_req,
    output logic o_busy,
    output mcdbo_pkg::mcdbo_res_t o_res
);

    mcdbo_pkg::mcdbo_state_t st;
    mcdbo_pkg::mcdbo_state_t next_st;

    // arithmetic results, computed for every request
    logic [`MCDBO_DATA_W:0] diff_ext;
    logic [`MCDBO_DATA_W-1:0] dec_val;
    logic [`MCDBO_DATA_W-1:0] adj_val;
    logic adj_carry;
    logic dec_is_zero;
    logic take;

    // a request arriving during the skip cycle is the squashed instruction
    assign take = i_req_valid && (st.fsm == mcdbo_pkg::MCDBO_ST_RUN);

    // ninth bit of the widened difference is the borrow; carry is its inverse
    assign diff_ext = {1'b0, i_req.reg_data} - {1'b0, i_req.accumulator};
    assign dec_val = i_req.reg_data - 8'h01;
    assign dec_is_zero = (dec_val == `MCDBO_RST_BYTE);

    always_comb begin
        logic [`MCDBO_DATA_W-1:0] lo_fix;
        logic [`MCDBO_DATA_W-1:0] step;
        lo_fix = `MCDBO_RST_BYTE;
        step = i_req.accumulator;
        adj_carry = `MCDBO_RST_BIT;
        // low nibble first; its carry may push the high nibble past nine
        if (i_req.accumulator[3:0] > `MCDBO_NIB_MAX) begin
            lo_fix = `MCDBO_ADJ_LO_ADD;
        end
        step = i_req.accumulator + lo_fix;
        if ((step[7:4] > `MCDBO_NIB_MAX) || i_req.carry) begin
            step = step + `MCDBO_ADJ_HI_ADD;
            adj_carry = 1'b1;
        end
        adj_val = step;
    end

    always_comb begin
        next_st = st;
        // enables and squash are pulses; cleared unless set below
        next_st.res.accum_we = 1'b0;
        next_st.res.reg_we = 1'b0;
        next_st.res.zero_we = 1'b0;
        next_st.res.carry_we = 1'b0;
        next_st.res.squash = 1'b0;
        next_st.busy = 1'b0;
        case (st.fsm)
            mcdbo_pkg::MCDBO_ST_RUN: begin
                if (take) begin
                    next_st.res.reg_addr = i_req.reg_addr;
                    case (i_req.op)
                        mcdbo_pkg::MCDBO_OP_COMPARE_ACC_WITH_REG: begin
                            // difference goes to flags only, no data enable
                            next_st.res.zero_we = 1'b1;
                            next_st.res.zero = (diff_ext[7:0] == `MCDBO_RST_BYTE);
                            next_st.res.carry_we = 1'b1;
                            next_st.res.carry = ~diff_ext[8];
                            next_st.res.accum_we = 1'b0;
                            next_st.res.reg_we = 1'b0;
                        end
                        mcdbo_pkg::MCDBO_OP_DECREMENT_REG: begin
                            if (i_req.dest == `MCDBO_DEST_REG) begin
                                next_st.res.reg_we = 1'b1;
                                next_st.res.reg_data = dec_val;
                            end else begin
                                next_st.res.accum_we = 1'b1;
                                next_st.res.accum_data = dec_val;
                            end
                            next_st.res.zero_we = 1'b1;
                            next_st.res.zero = dec_is_zero;
                        end
                        mcdbo_pkg::MCDBO_OP_DECIMAL_ADJUST_ACC: begin
                            next_st.res.accum_we = 1'b1;
                            next_st.res.accum_data = adj_val;
                            next_st.res.carry_we = 1'b1;
                            next_st.res.carry = adj_carry;
                        end
                        mcdbo_pkg::MCDBO_OP_DECREMENT_SKIP_IF_ZERO: begin
                            // flags are left alone by this instruction
                            if (i_req.dest == `MCDBO_DEST_REG) begin
                                next_st.res.reg_we = 1'b1;
                                next_st.res.reg_data = dec_val;
                            end else begin
                                next_st.res.accum_we = 1'b1;
                                next_st.res.accum_data = dec_val;
                            end
                            if (dec_is_zero) begin
                                next_st.res.squash = 1'b1;
                                next_st.busy = 1'b1;
                                next_st.fsm = mcdbo_pkg::MCDBO_ST_SKIP;
                            end
                        end
                        default: begin
                            next_st.res.squash = 1'b0;
                        end
                    endcase
                end
            end
            mcdbo_pkg::MCDBO_ST_SKIP: begin
                // the dropped instruction runs as a no-operation here
                next_st.fsm = mcdbo_pkg::MCDBO_ST_RUN;
            end
            default: begin
                next_st.fsm = mcdbo_pkg::MCDBO_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st.fsm <= mcdbo_pkg::MCDBO_ST_RUN;
            st.busy <= 1'b0;
            st.res.accum_we <= 1'b0;
            st.res.accum_data <= `MCDBO_RST_BYTE;
            st.res.reg_we <= 1'b0;
            st.res.reg_addr <= `MCDBO_RST_ADDR;
            st.res.reg_data <= `MCDBO_RST_BYTE;
            st.res.zero_we <= 1'b0;
            st.res.zero <= `MCDBO_RST_BIT;
            st.res.carry_we <= 1'b0;
            st.res.carry <= `MCDBO_RST_BIT;
            st.res.squash <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign o_busy = st.busy;
    assign o_res = st.res;

endmodule : mcdbo_core

`default_nettype wire

// ===== mcdbo_core_sva.sv
/* Checker of mcdbo_core write-back against the request taken one edge before.
   Assumes it is bound to mcdbo_core and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module mcdbo_core_sva (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire mcdbo_pkg::mcdbo_req_t i_req,
    input wire logic o_busy,
    input wire mcdbo_pkg::mcdbo_res_t o_res
);
    // one-hot op of the request taken at the last edge
    logic [3:0] k;
    mcdbo_pkg::mcdbo_req_t q;
    always_ff @(posedge i_mclk) begin
        k <= {4{i_req_valid && !o_busy && !i_rst}} & (4'h1 << i_req.op);
        q <= i_req;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_cmp;
        k[0] |-> o_res.zero_we && o_res.carry_we && o_res.zero == (q.reg_data == q.accumulator)
            && o_res.carry == (q.reg_data >= q.accumulator);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare flags");
    property p_cnw; k[0] |-> !o_res.accum_we && !o_res.reg_we; endproperty
    a_cnw: assert property (p_cnw) else $error("compare wrote");
    property p_dec; k[1] |-> o_res.zero_we && !o_res.carry_we && o_res.zero == (q.reg_data == 8'h01); endproperty
    a_dec: assert property (p_dec) else $error("decrement flag");
    property p_dst; (k[1] || k[3]) && q.dest |-> o_res.reg_we && o_res.reg_data == q.reg_data - 8'h01; endproperty
    a_dst: assert property (p_dst) else $error("register write");
    property p_dsa;
        (k[1] || k[3]) && !q.dest |-> o_res.accum_we && o_res.accum_data == q.reg_data - 8'h01;
    endproperty
    a_dsa: assert property (p_dsa) else $error("accumulator write");
    property p_adj; k[2] |-> o_res.accum_we && o_res.carry_we && !o_res.zero_we && !o_res.reg_we; endproperty
    a_adj: assert property (p_adj) else $error("adjust enables");
    property p_skp; k[3] |-> o_res.squash == (q.reg_data == 8'h01) && !o_res.zero_we; endproperty
    a_skp: assert property (p_skp) else $error("skip squash");
    property p_one; o_busy |-> o_res.squash ##1 !o_busy && !o_res.accum_we && !o_res.reg_we; endproperty
    a_one: assert property (p_one) else $error("skip length");
    c_skp: cover property (k[3] && o_busy);
    c_adj: cover property (k[2] && o_res.carry);
    c_cmp: cover property (k[0] && o_res.zero);
endmodule : mcdbo_core_sva
bind mcdbo_core mcdbo_core_sva i_sva (.i_mclk(i_mclk), .i_rst(i_rst), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_busy(o_busy), .o_res(o_res));
`default_nettype wire

// ===== mcdbo_core_bench.sv
/* Self-checking bench of mcdbo_core with an in-bench model.
   Assumes mcdbo_pkg and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("Error %0t %h %h", $time, a, b); end end
module mcdbo_core_bench;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_req_valid = 1'b0;
    mcdbo_pkg::mcdbo_req_t i_req = '0;
    logic o_busy;
    mcdbo_pkg::mcdbo_res_t o_res;
    logic [31:0] lf = 32'h108DB;
    int n_errors = 0;
    int total_checks = 0;
    mcdbo_core i_mcdbo_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
        .o_busy(o_busy), .o_res(o_res));
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    function automatic logic [8:0] dec_adjust(input logic [7:0] a, input logic c);
        logic [7:0] v;
        v = a + ((a[3:0] > 4'h9) ? 8'h06 : 8'h00);
        return (c || v[7:4] > 4'h9) ? {1'b1, v + 8'h60} : {1'b0, v};
    endfunction : dec_adjust
    task automatic go(input logic [1:0] op, input logic [7:0] r, input logic [7:0] a, input logic d);
        logic [5:0] e;
        logic sk;
        logic [5:0] got;
        logic [13:0] wb;
        sk = op == 2'h3 && r == 8'h01;
        e = {op == 2'h2 || op[0] && !d, op[0] && d, !op[1], !op[0], sk, sk};
        i_req_valid = 1'b1;
        i_req = '{mcdbo_pkg::mcdbo_op_t'(op), lf[13:8], d, r, a, lf[4]};
        @(posedge i_mclk);
        #1;
        got = {o_res.accum_we, o_res.reg_we, o_res.zero_we, o_res.carry_we, o_res.squash, o_busy};
        wb = d ? {o_res.reg_addr, o_res.reg_data} : {lf[13:8], o_res.accum_data};
        `CHK(got, e)
        if (op == 2'h0) `CHK({o_res.zero, o_res.carry}, {r == a, r >= a})
        if (op == 2'h1) `CHK(o_res.zero, r == 8'h01)
        if (op[0]) `CHK(wb, {lf[13:8], r - 8'h01})
        if (op == 2'h2) `CHK({o_res.carry, o_res.accum_data}, dec_adjust(a, lf[4]))
        if (sk) begin
            // the request standing in the skip cycle must be dropped
            @(posedge i_mclk);
            #1;
            `CHK({o_res.accum_we, o_res.reg_we, o_res.squash, o_busy}, 4'h0)
        end
        lf = nx(lf);
    endtask : go
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    initial begin
        #20000;
        n_errors++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        #1;
        i_rst = 1'b0;
        go(2'h0, 8'h34, 8'h12, 1'b0);
        go(2'h0, 8'h12, 8'h12, 1'b1);
        go(2'h1, 8'h01, 8'h00, 1'b1);
        go(2'h1, 8'h00, 8'h00, 1'b0);
        go(2'h2, 8'h00, 8'h7B, 1'b0);
        go(2'h2, 8'h00, 8'h9A, 1'b0);
        go(2'h3, 8'h01, 8'h00, 1'b0);
        go(2'h3, 8'h01, 8'h00, 1'b1);
        $display("directed done");
        i_rst = 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK({o_busy, o_res}, '0)
        i_rst = 1'b0;
        $display("reset done");
        repeat (300) go(lf[1:0], lf[5] ? 8'h01 : lf[31:24], lf[23:16], lf[6]);
        i_req_valid = 1'b0;
        $display("random done");
        test_done;
    end
endmodule : mcdbo_core_bench
`default_nettype wire
